// *** common/dsp_alu_pkg.sv ***
package dsp_alu_pkg;

	// datapath widths
	localparam int WORD_W = 24;
	localparam int EXT_W = 8;
	localparam int ACC_W = 56;
	localparam int PAIR_W = 48;
	localparam int OPERAND_W = 25;
	localparam int FULL_PROD_W = 50;
	localparam int SHIFT_W = 7;
	localparam int FIELD_W = 6;
	localparam int NARROW_PAD = 8;

	// reset values
	localparam logic [WORD_W-1:0] INPUT_RESET = 24'h000000;
	localparam logic [ACC_W-1:0] ACC_RESET = 56'h00000000000000;
	localparam logic [PAIR_W-1:0] READ_RESET = 48'h000000000000;

	// limiter values, one 24-bit word each
	localparam logic [WORD_W-1:0] LIMIT_POS_WORD = 24'h7FFFFF;
	localparam logic [WORD_W-1:0] LIMIT_NEG_WORD = 24'h800000;
	localparam logic [WORD_W-1:0] LIMIT_POS_LOW = 24'hFFFFFF;
	localparam logic [WORD_W-1:0] LIMIT_NEG_LOW = 24'h000000;

	// rounding constants: half of the upper word's lsb
	localparam logic [ACC_W-1:0] ROUND_HALF_24 = 56'h00000000800000;
	localparam logic [ACC_W-1:0] ROUND_HALF_16 = 56'h00000080000000;
	localparam logic [ACC_W-1:0] LOWER_CLEAR = 56'hFFFFFFFF000000;
	// 16-bit mode keeps 8 + 16 + 16 bits of an accumulator
	localparam logic [ACC_W-1:0] MASK_16 = 56'hFFFFFF00FFFF00;
	localparam logic [ACC_W-1:0] ONE_56 = 56'h00000000000001;

	// input register indices
	localparam logic [1:0] IDX_X_LOW = 2'h0;
	localparam logic [1:0] IDX_X_HIGH = 2'h1;
	localparam logic [1:0] IDX_Y_LOW = 2'h2;
	localparam logic [1:0] IDX_Y_HIGH = 2'h3;

	typedef enum logic [3:0] {
		op_nop, op_clr, op_mpy, op_mac, op_add, op_sub, op_and, op_or,
		op_xor, op_shift, op_norm, op_extract, op_transfer
	} alu_op_e;

	typedef enum logic [3:0] {
		sel_input_reg_x_low, sel_input_reg_x_high,
		sel_input_reg_y_low, sel_input_reg_y_high,
		sel_acc_first_extension, sel_acc_first_upper, sel_acc_first_lower,
		sel_acc_second_extension, sel_acc_second_upper,
		sel_acc_second_lower, sel_acc_first, sel_acc_second,
		sel_input_pair_x, sel_input_pair_y
	} reg_sel_e;

	typedef struct packed {
		logic [EXT_W-1:0] result_extension_part;
		logic [WORD_W-1:0] upper;
		logic [WORD_W-1:0] lower;
	} acc_s;

	typedef struct packed {
		logic valid;
		alu_op_e op;
		logic dest;
		logic src_acc;
		logic [1:0] mul_a;
		logic [1:0] mul_b;
		logic signed_a;
		logic signed_b;
		logic round;
		logic conditional;
		logic [SHIFT_W-1:0] shift;
		logic arith;
		logic [FIELD_W-1:0] field_w;
	} alu_cmd_s;

	typedef struct packed {
		logic wr;
		logic rd;
		reg_sel_e sel;
		logic wide;
		logic [PAIR_W-1:0] data;
	} bus_req_s;

	typedef struct packed {
		logic zero;
		logic negative;
		logic ext_in_use;
		logic [SHIFT_W-1:0] norm_count;
	} status_s;

endpackage

// *** verilog/dsp_alu_barrel_shifter.sv ***
`timescale 1ns/1ps
`default_nettype none
module dsp_alu_barrel_shifter
	import dsp_alu_pkg::*;
(
	// operand and control
	input wire logic [ACC_W-1:0] value,
	input wire logic [SHIFT_W-1:0] amount,
	input wire logic arith,
	input wire logic normalize,
	// results
	output logic [ACC_W-1:0] shifted,
	output logic [SHIFT_W-1:0] norm_amount
);

	logic [SHIFT_W-1:0] redundant; // copies of the sign below bit 55
	logic [SHIFT_W-1:0] eff; // signed shift actually applied
	logic [SHIFT_W-1:0] mag; // its magnitude
	logic run; // still inside the run of sign copies

	// count redundant sign bits, giving the normalising exponent
	always_comb
	begin
		redundant = '0;
		run = 1'b1;
		for (int i = ACC_W - 2; i >= 0; i--)
		begin
			if (run && (value[i] == value[ACC_W-1]))
				redundant = redundant + 7'h01;
			else
				run = 1'b0;
		end
		// the extension byte is headroom, so normalise to bit 47
		norm_amount = redundant - SHIFT_W'(EXT_W);
	end

	// one parallel stage: positive shifts left, negative shifts right
	always_comb
	begin
		eff = normalize ? norm_amount : amount;
		mag = eff[SHIFT_W-1] ? (~eff + 7'h01) : eff;
		if (!eff[SHIFT_W-1])
			shifted = value << mag;
		else if (arith || normalize)
			shifted = ACC_W'($signed(value) >>> mag);
		else
			shifted = value >> mag;
	end

endmodule
`default_nettype wire

// *** verilog/dsp_data_alu_mac.sv ***
`timescale 1ns/1ps
`default_nettype none
module dsp_data_alu_mac
	import dsp_alu_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// mode and condition from the decoder
	input wire logic mode16,
	input wire logic cond_true,
	// operation issue
	input wire alu_cmd_s cmd,
	// data memory buses
	input wire bus_req_s first_data_memory_bus,
	input wire bus_req_s second_data_memory_bus,
	output logic [PAIR_W-1:0] first_rd_data,
	output logic [PAIR_W-1:0] second_rd_data,
	// result status
	output status_s status
);

	logic [WORD_W-1:0] in_reg [4]; // x low, x high, y low, y high
	acc_s acc_reg [2]; // first and second accumulator
	alu_cmd_s s1_reg; // operation in the second stage
	logic [ACC_W-1:0] prod_reg; // stage one product
	logic [ACC_W-1:0] prod_next;
	logic [OPERAND_W-1:0] op_a;
	logic [OPERAND_W-1:0] op_b;
	logic signed [FULL_PROD_W-1:0] full_prod;
	logic [ACC_W-1:0] acc_src; // destination accumulator value
	logic [ACC_W-1:0] operand; // third operand
	logic [ACC_W-1:0] sum;
	logic [ACC_W-1:0] result;
	logic [ACC_W-1:0] shifted;
	logic [ACC_W-1:0] field_mask;
	logic [SHIFT_W-1:0] norm_amount;
	logic result_we;
	logic [PAIR_W-1:0] first_rd_next;
	logic [PAIR_W-1:0] second_rd_next;

	// saturating limiter, one copy in each of the two bus read paths
	function automatic logic [PAIR_W-1:0] limit(input acc_s a,
		input logic wide);
		logic over;
		logic [PAIR_W-1:0] r;
		over = (a.result_extension_part != {EXT_W{a.upper[WORD_W-1]}});
		r = {a.upper, a.lower};
		if (over && a.result_extension_part[EXT_W-1])
			r = {LIMIT_NEG_WORD, LIMIT_NEG_LOW};
		else if (over)
			r = {LIMIT_POS_WORD, LIMIT_POS_LOW};
		// a single-word store keeps only the upper word
		limit = wide ? r : {{WORD_W{1'b0}}, r[PAIR_W-1:WORD_W]};
	endfunction

	// read decode for one bus, narrowed in 16-bit mode
	function automatic logic [PAIR_W-1:0] bus_read(input bus_req_s b,
		input logic m16, input logic [WORD_W-1:0] x0,
		input logic [WORD_W-1:0] x1, input logic [WORD_W-1:0] y0,
		input logic [WORD_W-1:0] y1, input acc_s fa, input acc_s sa);
		logic [PAIR_W-1:0] r;
		logic pair;
		pair = 1'b1;
		r = '0;
		if (b.sel == sel_input_reg_x_low)
			r[WORD_W-1:0] = x0;
		else if (b.sel == sel_input_reg_x_high)
			r[WORD_W-1:0] = x1;
		else if (b.sel == sel_input_reg_y_low)
			r[WORD_W-1:0] = y0;
		else if (b.sel == sel_input_reg_y_high)
			r[WORD_W-1:0] = y1;
		else if (b.sel == sel_acc_first_extension)
			r[WORD_W-1:0] = WORD_W'($signed(fa.result_extension_part));
		else if (b.sel == sel_acc_first_upper)
			r[WORD_W-1:0] = fa.upper;
		else if (b.sel == sel_acc_first_lower)
			r[WORD_W-1:0] = fa.lower;
		else if (b.sel == sel_acc_second_extension)
			r[WORD_W-1:0] = WORD_W'($signed(sa.result_extension_part));
		else if (b.sel == sel_acc_second_upper)
			r[WORD_W-1:0] = sa.upper;
		else if (b.sel == sel_acc_second_lower)
			r[WORD_W-1:0] = sa.lower;
		else if (b.sel == sel_acc_first)
			r = limit(fa, b.wide);
		else if (b.sel == sel_acc_second)
			r = limit(sa, b.wide);
		else if (b.sel == sel_input_pair_x)
			r = {x1, x0};
		else if (b.sel == sel_input_pair_y)
			r = {y1, y0};
		else
			pair = 1'b0;
		// 16-bit data sits in the top of each word
		if (m16 && pair && b.wide)
			r = {{(PAIR_W-32){1'b0}}, r[47:32], r[23:8]};
		else if (m16 && pair)
			r = {{(PAIR_W-16){1'b0}}, r[23:8]};
		bus_read = r;
	endfunction

	// widen one bus word to register alignment in 16-bit mode
	function automatic logic [WORD_W-1:0] bus_word(
		input logic [WORD_W-1:0] d, input logic m16);
		bus_word = m16 ? {d[15:0], {NARROW_PAD{1'b0}}} : d;
	endfunction

	// stage one: operands from input registers only
	always_comb
	begin
		op_a = {cmd.signed_a & in_reg[cmd.mul_a][WORD_W-1],
			in_reg[cmd.mul_a]};
		op_b = {cmd.signed_b & in_reg[cmd.mul_b][WORD_W-1],
			in_reg[cmd.mul_b]};
		full_prod = $signed(op_a) * $signed(op_b);
		// fractional: one left shift, right-justified in 56 bits
		prod_next = ACC_W'({{(ACC_W-FULL_PROD_W){full_prod[FULL_PROD_W-1]}},
			full_prod} << 1);
	end

	// stage one register; squashed when condition fails
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			s1_reg <= '0;
			prod_reg <= ACC_RESET;
		end
		else
		begin
			s1_reg <= cmd;
			s1_reg.valid <= cmd.valid && (!cmd.conditional || cond_true);
			prod_reg <= prod_next;
		end
	end

	// barrel shifter on the destination accumulator
	dsp_alu_barrel_shifter shifter_u (
		.value(acc_src),
		.amount(s1_reg.shift),
		.arith(s1_reg.arith),
		.normalize(s1_reg.op == op_norm),
		.shifted(shifted),
		.norm_amount(norm_amount)
	);

	// stage two: reads the live accumulator, so a result written last
	// cycle is already visible and no stall is needed
	always_comb
	begin
		acc_src = acc_reg[s1_reg.dest];
		if (s1_reg.src_acc)
			operand = acc_reg[~s1_reg.dest];
		else if (s1_reg.mul_a[1])
			operand = ACC_W'($signed({in_reg[IDX_Y_HIGH], in_reg[IDX_Y_LOW]}));
		else
			operand = ACC_W'($signed({in_reg[IDX_X_HIGH], in_reg[IDX_X_LOW]}));
		field_mask = (ONE_56 << s1_reg.field_w) - ONE_56;
		sum = '0;
		case (s1_reg.op)
			op_clr: sum = ACC_RESET;
			op_mpy: sum = prod_reg;
			op_mac: sum = acc_src + prod_reg;
			op_add: sum = acc_src + operand;
			op_sub: sum = acc_src - operand;
			op_and: sum = acc_src & operand;
			op_or: sum = acc_src | operand;
			op_xor: sum = acc_src ^ operand;
			op_shift: sum = shifted;
			op_norm: sum = shifted;
			op_extract: sum = shifted & field_mask;
			op_transfer: sum = operand;
			default: sum = acc_src;
		endcase
		result = sum;
		// round to nearest, then drop the lower word
		if (s1_reg.round && (s1_reg.op == op_mpy || s1_reg.op == op_mac))
			result = (sum + (mode16 ? ROUND_HALF_16 : ROUND_HALF_24))
				& LOWER_CLEAR;
		if (mode16)
			result = result & MASK_16;
		result_we = s1_reg.valid && (s1_reg.op != op_nop);
	end

	// input registers; first bus wins over second on a clash
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			for (int i = 0; i < 4; i++)
				in_reg[i] <= INPUT_RESET;
		end
		else
		begin
			for (int k = 0; k < 2; k++)
			begin
				bus_req_s b;
				b = (k == 0) ? second_data_memory_bus : first_data_memory_bus;
				if (b.wr)
				begin
					// individual loads
					if (b.sel == sel_input_reg_x_low)
						in_reg[IDX_X_LOW] <= bus_word(b.data[23:0], mode16);
					else if (b.sel == sel_input_reg_x_high)
						in_reg[IDX_X_HIGH] <= bus_word(b.data[23:0], mode16);
					else if (b.sel == sel_input_reg_y_low)
						in_reg[IDX_Y_LOW] <= bus_word(b.data[23:0], mode16);
					else if (b.sel == sel_input_reg_y_high)
						in_reg[IDX_Y_HIGH] <= bus_word(b.data[23:0], mode16);
					else if (b.sel == sel_input_pair_x)
					begin
						in_reg[IDX_X_HIGH] <= bus_word(b.data[47:24], mode16);
						in_reg[IDX_X_LOW] <= bus_word(b.data[23:0], mode16);
					end
					else if (b.sel == sel_input_pair_y)
					begin
						in_reg[IDX_Y_HIGH] <= bus_word(b.data[47:24], mode16);
						in_reg[IDX_Y_LOW] <= bus_word(b.data[23:0], mode16);
					end
				end
			end
		end
	end

	// accumulators: alu result first, bus writes override it
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			acc_reg[0] <= ACC_RESET;
			acc_reg[1] <= ACC_RESET;
		end
		else
		begin
			if (result_we)
				acc_reg[s1_reg.dest] <= result;
			for (int k = 0; k < 2; k++)
			begin
				bus_req_s b;
				logic [WORD_W-1:0] hi;
				logic [WORD_W-1:0] lo;
				b = (k == 0) ? second_data_memory_bus : first_data_memory_bus;
				hi = bus_word(b.data[47:24], mode16);
				lo = bus_word(b.data[23:0], mode16);
				if (b.wr)
				begin
					// each part addressable on its own
					if (b.sel == sel_acc_first_extension)
						acc_reg[0].result_extension_part <= b.data[EXT_W-1:0];
					else if (b.sel == sel_acc_first_upper)
						acc_reg[0].upper <= lo;
					else if (b.sel == sel_acc_first_lower)
						acc_reg[0].lower <= lo;
					else if (b.sel == sel_acc_second_extension)
						acc_reg[1].result_extension_part <= b.data[EXT_W-1:0];
					else if (b.sel == sel_acc_second_upper)
						acc_reg[1].upper <= lo;
					else if (b.sel == sel_acc_second_lower)
						acc_reg[1].lower <= lo;
					// whole accumulator: sign-extend into extension
					else if (b.sel == sel_acc_first && b.wide)
						acc_reg[0] <= {{EXT_W{hi[WORD_W-1]}}, hi, lo};
					else if (b.sel == sel_acc_first)
						acc_reg[0] <= {{EXT_W{lo[WORD_W-1]}}, lo, INPUT_RESET};
					else if (b.sel == sel_acc_second && b.wide)
						acc_reg[1] <= {{EXT_W{hi[WORD_W-1]}}, hi, lo};
					else if (b.sel == sel_acc_second)
						acc_reg[1] <= {{EXT_W{lo[WORD_W-1]}}, lo, INPUT_RESET};
				end
			end
		end
	end

	// read paths, one limiter each
	assign first_rd_next = bus_read(first_data_memory_bus, mode16,
		in_reg[IDX_X_LOW], in_reg[IDX_X_HIGH], in_reg[IDX_Y_LOW],
		in_reg[IDX_Y_HIGH], acc_reg[0], acc_reg[1]);
	assign second_rd_next = bus_read(second_data_memory_bus, mode16,
		in_reg[IDX_X_LOW], in_reg[IDX_X_HIGH], in_reg[IDX_Y_LOW],
		in_reg[IDX_Y_HIGH], acc_reg[0], acc_reg[1]);

	// registered read data; holds when no read is made
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			first_rd_data <= READ_RESET;
			second_rd_data <= READ_RESET;
		end
		else
		begin
			if (first_data_memory_bus.rd)
				first_rd_data <= first_rd_next;
			if (second_data_memory_bus.rd)
				second_rd_data <= second_rd_next;
		end
	end

	// status of the last written result
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			status <= '0;
		else if (result_we)
		begin
			status.zero <= (result == ACC_RESET);
			status.negative <= result[ACC_W-1];
			status.ext_in_use <= (result[ACC_W-1:PAIR_W-1]
				!= {(EXT_W+1){result[ACC_W-1]}});
			if (s1_reg.op == op_norm)
				status.norm_count <= norm_amount; // exponent for software
		end
	end

endmodule
`default_nettype wire

// *** tb/dsp_data_alu_mac_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module dsp_data_alu_mac_checker
	import dsp_alu_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// decoder side
	input wire logic mode16,
	input wire logic cond_true,
	input wire alu_cmd_s cmd,
	// data memory buses
	input wire bus_req_s first_data_memory_bus,
	input wire bus_req_s second_data_memory_bus,
	input wire logic [PAIR_W-1:0] first_rd_data,
	input wire logic [PAIR_W-1:0] second_rd_data,
	// result status
	input wire status_s status
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	// short names for the two buses
	wire bus_req_s fb = first_data_memory_bus;
	wire bus_req_s sb = second_data_memory_bus;
	// narrow write of x_low on the first bus, full width mode
	sequence s_put_xl;
		fb.wr && fb.sel == sel_input_reg_x_low && !fb.wide && !mode16;
	endsequence
	// a cycle with no bus write at all
	sequence s_quiet;
		!fb.wr && !sb.wr;
	endsequence
	// conditional operation that stage one squashes
	sequence s_squash;
		cmd.valid && cmd.conditional && !cond_true;
	endsequence
	// clear that really executes
	sequence s_clear;
		cmd.valid && cmd.op == op_clr && (!cmd.conditional || cond_true);
	endsequence
	a_first_write_read: assert property (s_put_xl ##1 s_quiet ##1
		(fb.rd && fb.sel == sel_input_reg_x_low && !fb.wide && !mode16)
		|=> first_rd_data[23:0] == $past(fb.data[23:0], 3))
		else $error("first bus read of x_low differs from write");
	a_second_write_read: assert property (s_put_xl ##1 s_quiet ##1
		(sb.rd && sb.sel == sel_input_reg_x_low && !sb.wide && !mode16)
		|=> second_rd_data[23:0] == $past(fb.data[23:0], 3))
		else $error("second bus read of x_low differs from write");
	a_mode16_round_trip: assert property (
		(fb.wr && fb.sel == sel_input_reg_x_low && !fb.wide && mode16)
		##1 (s_quiet and mode16) ##1
		(fb.rd && fb.sel == sel_input_reg_x_low && !fb.wide && mode16)
		|=> first_rd_data[15:0] == $past(fb.data[15:0], 3))
		else $error("16-bit mode read differs from write");
	a_first_rd_hold: assert property (!fb.rd |=> $stable(first_rd_data))
		else $error("first read data moved without a read");
	a_second_rd_hold: assert property (!sb.rd |=> $stable(second_rd_data))
		else $error("second read data moved without a read");
	a_ext_sign_read: assert property (
		fb.rd && fb.sel == sel_acc_first_extension && !fb.wide && !mode16
		|=> first_rd_data[23:7] == 17'h00000 || &first_rd_data[23:7])
		else $error("extension read not sign extended");
	a_clear_zero: assert property (s_clear ##1 s_quiet
		|=> status.zero && !status.negative)
		else $error("clear did not leave a zero result");
	a_squash_status: assert property (s_squash ##1 s_quiet
		|=> $stable(status))
		else $error("squashed operation changed status");
	a_status_exclusive: assert property (!(status.zero && status.negative))
		else $error("status both zero and negative");
endmodule
bind dsp_data_alu_mac dsp_data_alu_mac_checker dsp_data_alu_mac_checker_inst (
	.clock(clock),
	.rst_b(rst_b),
	.mode16(mode16),
	.cond_true(cond_true),
	.cmd(cmd),
	.first_data_memory_bus(first_data_memory_bus),
	.second_data_memory_bus(second_data_memory_bus),
	.first_rd_data(first_rd_data),
	.second_rd_data(second_rd_data),
	.status(status)
);
`default_nettype wire

// *** tb/data_bus_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module data_bus_model
	import dsp_alu_pkg::*;
(
	// clock
	input wire logic clock,
	// bus toward the unit
	input wire logic [PAIR_W-1:0] rd_data,
	output var bus_req_s bus
);
	// idle at start, nothing requested
	initial bus = '0;
	// one transfer: drive after an edge, hold to the next, then release;
	// released data shows the inverse so stale values never look valid
	task automatic xfer(input logic wr, input reg_sel_e sel,
		input logic wide, input logic [PAIR_W-1:0] data,
		output logic [PAIR_W-1:0] got);
		@(posedge clock);
		#1;
		bus.wr = wr;
		bus.rd = !wr;
		bus.sel = sel;
		bus.wide = wide;
		bus.data = data;
		@(posedge clock);
		#1;
		got = rd_data;
		bus.wr = 1'b0;
		bus.rd = 1'b0;
		bus.data = ~data;
	endtask
endmodule
`default_nettype wire

// *** tb/dsp_data_alu_mac_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module dsp_data_alu_mac_tb
	import dsp_alu_pkg::*;
();
	// clock, reset and decoder side
	logic clock, rst_b, mode16, cond_true;
	alu_cmd_s cmd;
	// buses, read data and status
	bus_req_s fbus, sbus;
	logic [PAIR_W-1:0] frd, srd;
	status_s status;
	// verdict counters
	int miscompares, compares;
	// compare masks: narrow, wide, 16-bit mode
	localparam logic [PAIR_W-1:0] M24 = 48'h000000FFFFFF;
	localparam logic [PAIR_W-1:0] M48 = 48'hFFFFFFFFFFFF;
	localparam logic [PAIR_W-1:0] M16 = 48'h00000000FFFF;
	dsp_data_alu_mac dsp_data_alu_mac_inst (.clock(clock), .rst_b(rst_b),
		.mode16(mode16), .cond_true(cond_true), .cmd(cmd),
		.first_data_memory_bus(fbus), .second_data_memory_bus(sbus),
		.first_rd_data(frd), .second_rd_data(srd), .status(status));
	data_bus_model first_inst (.clock(clock), .rd_data(frd), .bus(fbus));
	data_bus_model second_inst (.clock(clock), .rd_data(srd), .bus(sbus));
	// 25 MHz core clock
	always #20 clock = ~clock;
	// data comparison
	task automatic check48(input logic [PAIR_W-1:0] got, exp);
		compares++;
		if (got !== exp)
		begin
			miscompares++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// status flag comparison
	task automatic check_flag(input logic got, exp);
		compares++;
		if (got !== exp)
		begin
			miscompares++;
			$display("MISMATCH at %0t: flag %b expected %b", $time, got, exp);
		end
	endtask
	// register write through one bus
	task automatic put(input logic which, input reg_sel_e sel,
		input logic wide, input logic [PAIR_W-1:0] data);
		logic [PAIR_W-1:0] got;
		if (which)
			second_inst.xfer(1'b1, sel, wide, data, got);
		else
			first_inst.xfer(1'b1, sel, wide, data, got);
	endtask
	// register read, only masked bits are judged
	task automatic get(input logic which, input reg_sel_e sel,
		input logic wide, input logic [PAIR_W-1:0] mask, exp);
		logic [PAIR_W-1:0] got;
		if (which)
			second_inst.xfer(1'b0, sel, wide, 48'h0, got);
		else
			first_inst.xfer(1'b0, sel, wide, 48'h0, got);
		check48(got & mask, exp);
	endtask
	// issue one operation; stays valid so issues can run back to back
	task automatic issue(input alu_op_e op, input logic dest,
		input logic [1:0] a, b, input logic sa, rnd, cnd,
		input logic [SHIFT_W-1:0] sh);
		alu_cmd_s c;
		c = '0;
		c.valid = 1'b1;
		c.op = op;
		c.dest = dest;
		c.mul_a = a;
		c.mul_b = b;
		c.signed_a = sa;
		c.signed_b = 1'b1;
		c.round = rnd;
		c.conditional = cnd;
		c.shift = sh;
		cmd = c;
		@(posedge clock);
		#1;
	endtask
	// stop issuing and let the second stage write back
	task automatic drain;
		cmd = '0;
		@(posedge clock);
		#1;
	endtask
	// input registers, both buses, pair access
	task automatic t_inputs;
		get(1'b0, sel_input_reg_x_low, 1'b0, M24, 48'h0);
		for (int i = 0; i < 4; i++)
		begin
			put(1'b0, reg_sel_e'(i), 1'b0, 48'h000000A5A5A0 + 48'(i));
			get(i[0], reg_sel_e'(i), 1'b0, M24, 48'h000000A5A5A0 + 48'(i));
		end
		put(1'b0, sel_input_reg_x_low, 1'b0, 48'h000000C3C3C3);
		get(1'b1, sel_input_reg_x_low, 1'b0, M24, 48'h000000C3C3C3);
		put(1'b1, sel_input_pair_x, 1'b1, 48'h123456789ABC);
		get(1'b0, sel_input_reg_x_high, 1'b0, M24, 48'h000000123456);
		get(1'b1, sel_input_pair_x, 1'b1, M48, 48'h123456789ABC);
	endtask
	// accumulator parts and the limiter
	task automatic t_acc_parts;
		put(1'b0, sel_acc_first, 1'b1, 48'h400000000001);
		get(1'b0, sel_acc_first_lower, 1'b0, M24, 48'h000000000001);
		get(1'b0, sel_acc_first_extension, 1'b0, M24, 48'h0);
		put(1'b1, sel_acc_first_extension, 1'b0, 48'h0000000000FF);
		get(1'b0, sel_acc_first_extension, 1'b0, M24, 48'h000000FFFFFF);
		get(1'b1, sel_acc_first, 1'b0, M24, 48'h000000800000);
		get(1'b0, sel_acc_first, 1'b1, M48, 48'h800000000000);
	endtask
	// keep versus round of the lower product word
	task automatic t_round;
		put(1'b0, sel_input_reg_x_low, 1'b0, 48'h000000400001);
		put(1'b1, sel_input_reg_y_low, 1'b0, 48'h000000400000);
		issue(op_mpy, 1'b0, IDX_X_LOW, IDX_Y_LOW, 1'b1, 1'b0, 1'b0, 7'h00);
		drain;
		get(1'b0, sel_acc_first, 1'b1, M48, 48'h200000800000);
		issue(op_mpy, 1'b1, IDX_X_LOW, IDX_Y_LOW, 1'b1, 1'b1, 1'b0, 7'h00);
		drain;
		get(1'b1, sel_acc_second, 1'b1, M48, 48'h200001000000);
		get(1'b1, sel_acc_second_lower, 1'b0, M24, 48'h0);
	endtask
	// dependent operations every clock, ending in overflow
	task automatic t_mac_chain;
		put(1'b0, sel_input_reg_x_low, 1'b0, 48'h000000400000);
		issue(op_mpy, 1'b0, IDX_X_LOW, IDX_Y_LOW, 1'b1, 1'b0, 1'b0, 7'h00);
		repeat (3)
			issue(op_mac, 1'b0, IDX_X_LOW, IDX_Y_LOW, 1'b1, 1'b0, 1'b0, 7'h00);
		drain;
		check_flag(status.ext_in_use, 1'b1);
		get(1'b0, sel_acc_first_upper, 1'b0, M24, 48'h000000800000);
		get(1'b1, sel_acc_first, 1'b1, M48, 48'h7FFFFFFFFFFF);
	endtask
	// unsigned against signed operand
	task automatic t_mixed;
		put(1'b0, sel_input_reg_x_high, 1'b0, 48'h000000FFFFFF);
		put(1'b1, sel_input_reg_y_high, 1'b0, 48'h000000400000);
		for (int s = 0; s < 2; s++)
		begin
			issue(op_mpy, 1'b0, IDX_X_HIGH, IDX_Y_HIGH, s[0], 1'b0, 1'b0, 7'h00);
			drain;
			get(1'b0, sel_acc_first, 1'b1, M48,
				s[0] ? 48'hFFFFFF800000 : 48'h7FFFFF800000);
		end
	endtask
	// squashed then executed conditional clear
	task automatic t_cond;
		cond_true = 1'b0;
		issue(op_clr, 1'b0, IDX_X_LOW, IDX_X_LOW, 1'b1, 1'b0, 1'b1, 7'h00);
		drain;
		get(1'b0, sel_acc_first, 1'b1, M48, 48'hFFFFFF800000);
		cond_true = 1'b1;
		issue(op_clr, 1'b0, IDX_X_LOW, IDX_X_LOW, 1'b1, 1'b0, 1'b1, 7'h00);
		drain;
		check_flag(status.zero, 1'b1);
		get(1'b0, sel_acc_first, 1'b1, M48, 48'h0);
	endtask
	// 16-bit mode narrows the bus words
	task automatic t_mode16;
		mode16 = 1'b1;
		put(1'b0, sel_input_reg_x_low, 1'b0, 48'h000000001234);
		get(1'b0, sel_input_reg_x_low, 1'b0, M16, 48'h000000001234);
		mode16 = 1'b0;
		get(1'b0, sel_input_reg_x_low, 1'b0, M24, 48'h000000123400);
	endtask
	// left shift of an accumulator
	task automatic t_shift;
		put(1'b0, sel_acc_first, 1'b1, 48'h000001000000);
		issue(op_shift, 1'b0, IDX_X_LOW, IDX_X_LOW, 1'b1, 1'b0, 1'b0, 7'h04);
		drain;
		get(1'b0, sel_acc_first, 1'b1, M48, 48'h000010000000);
	endtask
	// add, dependent subtracts into negative, then normalise
	task automatic t_alu_ops;
		put(1'b0, sel_input_pair_x, 1'b1, 48'h000001000000);
		put(1'b1, sel_acc_first, 1'b1, 48'h000002000000);
		issue(op_add, 1'b0, IDX_X_LOW, IDX_X_LOW, 1'b1, 1'b0, 1'b0, 7'h00);
		drain;
		get(1'b0, sel_acc_first, 1'b1, M48, 48'h000003000000);
		check_flag(status.negative, 1'b0);
		repeat (4)
			issue(op_sub, 1'b0, IDX_X_LOW, IDX_X_LOW, 1'b1, 1'b0, 1'b0, 7'h00);
		drain;
		check_flag(status.negative, 1'b1);
		get(1'b0, sel_acc_first, 1'b1, M48, 48'hFFFFFF000000);
		issue(op_norm, 1'b0, IDX_X_LOW, IDX_X_LOW, 1'b1, 1'b0, 1'b0, 7'h00);
		drain;
		check48(48'(status.norm_count), 48'h000000000017);
		get(1'b1, sel_acc_first, 1'b1, M48, 48'h800000000000);
	endtask
	// verdict and end of run
	task automatic test_done;
		if (miscompares == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// main sequence after ten cycles of reset
	initial
	begin
		clock = 1'b0;
		rst_b = 1'b0;
		miscompares = 0;
		compares = 0;
		cmd = '0;
		mode16 = 1'b0;
		cond_true = 1'b1;
		repeat (10) @(posedge clock);
		#1;
		rst_b = 1'b1;
		t_inputs;
		t_acc_parts;
		t_round;
		t_mac_chain;
		t_mixed;
		t_cond;
		t_mode16;
		t_shift;
		t_alu_ops;
		test_done;
	end
	// watchdog: a hang counts as a mismatch
	initial
	begin
		#200000;
		miscompares++;
		test_done;
	end
endmodule
`default_nettype wire
